/* File: hdl/dft_pkg.sv */
// constants for the descriptor fifo bus request threshold block
package dft_pkg;
   // register byte addresses
   localparam logic [31:0] RX_DESC_THR_ADDR   = 32'h8001_00e0;
   localparam logic [31:0] TX_DESC_THR_ADDR   = 32'h8001_00e4;
   localparam logic [31:0] THR_RESET_VALUE    = 32'h0000_0000;
   // field layout: hard limit in the upper half, soft limit in the lower half
   localparam int          HARD_MSB           = 21;
   localparam int          HARD_LSB           = 16;
   localparam int          SOFT_MSB           = 5;
   localparam int          SOFT_LSB           = 0;
   localparam int          LIMIT_W            = 6;
   localparam int          ZERO_BITS          = 2;
   // fifo level and enqueue count widths
   localparam int          LEVEL_W            = 7;
   localparam int          ENQ_W              = 8;
   // idle qualification: four quiet bus clocks
   localparam int          IDLE_W             = 3;
   localparam logic [2:0]  IDLE_CLOCKS        = 3'h4;
endpackage

/* File: hdl/dft_threshold.sv */
// descriptor fifo bus request threshold logic with an apb register slave
// Notes on behaviour
// - each queue schedules a descriptor fetch once its empty fifo words exceed a threshold.
// - a scheduled request is not posted while that queue's enqueue count is zero.
// - the soft threshold raises a request only after four quiet bus clocks.
// - the hard threshold raises a request at once regardless of bus activity.
// - the two low bits of every threshold always count as zero.
// - both threshold registers clear to zero on chip reset and ignore soft reset.
// - reserved bits read back without meaning and software writes zero to fixed-zero bits.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module dft_threshold (
   input  wire logic                         clk_i,             // 25 mhz bus clock
   input  wire logic                         rstn_i,            // chip reset, sync, low
   input  wire logic                         soft_reset_i,      // mac soft reset
   input  wire logic                         psel_i,            // apb select
   input  wire logic                         penable_i,         // apb enable
   input  wire logic                         pwrite_i,          // apb direction
   input  wire logic [31:0]                  paddr_i,           // apb address
   input  wire logic [31:0]                  pwdata_i,          // apb write data
   output logic      [31:0]                  prdata_o,          // apb read data
   output logic                              pready_o,          // apb ready
   output logic                              pslverr_o,         // unmapped address
   input  wire logic                         ahb_transfer_i,    // a transfer on the bus
   input  wire logic [dft_pkg::LEVEL_W-1:0]  rx_empty_words_i,  // rx fifo empty words
   input  wire logic [dft_pkg::LEVEL_W-1:0]  tx_empty_words_i,  // tx fifo empty words
   input  wire logic [dft_pkg::ENQ_W-1:0]    rx_desc_enqueue_count_i, // rx descriptors ready
   input  wire logic [dft_pkg::ENQ_W-1:0]    tx_desc_enqueue_count_i, // tx descriptors ready
   input  wire logic                         rx_xfer_start_i,   // rx fetch begins
   input  wire logic                         tx_xfer_start_i,   // tx fetch begins
   output logic                              rx_bus_req_o,      // rx descriptor request
   output logic                              tx_bus_req_o,      // tx descriptor request
   output logic                              bus_idle_o         // bus deemed idle
);

   // only the meaningful upper bits of each limit are stored
   localparam int KEEP_W = dft_pkg::LIMIT_W - dft_pkg::ZERO_BITS;

   logic [KEEP_W-1:0]         rx_hard, rx_soft, tx_hard, tx_soft;
   logic [KEEP_W-1:0]         next_rx_hard, next_rx_soft, next_tx_hard, next_tx_soft;
   logic [31:0]               rdata, next_rdata;
   logic [dft_pkg::IDLE_W-1:0] idle_cnt, next_idle_cnt;
   logic                      idle, next_idle;
   logic                      rx_req, tx_req, next_rx_req, next_tx_req;
   logic                      setup, access, rx_hit, tx_hit;
   logic                      rx_hard_hit, rx_soft_hit, tx_hard_hit, tx_soft_hit;

   // limit with its fixed-zero low bits restored
   function automatic logic [dft_pkg::LEVEL_W-1:0] limit_words(input logic [KEEP_W-1:0] f);
      limit_words = dft_pkg::LEVEL_W'({f, {dft_pkg::ZERO_BITS{1'b0}}});
   endfunction

   // register image; reserved bits read as zero
   function automatic logic [31:0] pack_reg(input logic [KEEP_W-1:0] h,
                                             input logic [KEEP_W-1:0] s);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[dft_pkg::HARD_MSB:dft_pkg::HARD_LSB+dft_pkg::ZERO_BITS] = h;
      v[dft_pkg::SOFT_MSB:dft_pkg::SOFT_LSB+dft_pkg::ZERO_BITS] = s;
      pack_reg = v;
   endfunction

   // write-data fields, fixed-zero low bits dropped
   function automatic logic [KEEP_W-1:0] hard_field(input logic [31:0] w);
      hard_field = w[dft_pkg::HARD_MSB:dft_pkg::HARD_LSB+dft_pkg::ZERO_BITS];
   endfunction

   function automatic logic [KEEP_W-1:0] soft_field(input logic [31:0] w);
      soft_field = w[dft_pkg::SOFT_MSB:dft_pkg::SOFT_LSB+dft_pkg::ZERO_BITS];
   endfunction

   // strictly greater: a level equal to the limit asks for nothing
   function automatic logic over_limit(input logic [dft_pkg::LEVEL_W-1:0] e,
                                       input logic [KEEP_W-1:0]          f);
      over_limit = e > limit_words(f);
   endfunction

   assign setup     = psel_i && !penable_i;
   assign access    = psel_i && penable_i;
   assign rx_hit    = (paddr_i == dft_pkg::RX_DESC_THR_ADDR);
   assign tx_hit    = (paddr_i == dft_pkg::TX_DESC_THR_ADDR);
   assign pready_o  = access;
   assign pslverr_o = access && !rx_hit && !tx_hit;
   assign prdata_o  = rdata;

   // register file; soft reset deliberately has no effect here
   always_comb begin
      next_rx_hard = rx_hard;
      next_rx_soft = rx_soft;
      next_tx_hard = tx_hard;
      next_tx_soft = tx_soft;
      next_rdata   = rdata;
      if (setup && !pwrite_i) begin
         next_rdata = rx_hit ? pack_reg(rx_hard, rx_soft) :
                      tx_hit ? pack_reg(tx_hard, tx_soft) : 32'h0000_0000;
      end
      // written low bits are dropped, so limits stay multiples of four
      if (access && pwrite_i && rx_hit) begin
         next_rx_hard = hard_field(pwdata_i);
         next_rx_soft = soft_field(pwdata_i);
      end
      if (access && pwrite_i && tx_hit) begin
         next_tx_hard = hard_field(pwdata_i);
         next_tx_soft = soft_field(pwdata_i);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rx_hard <= KEEP_W'(dft_pkg::THR_RESET_VALUE);
         rx_soft <= KEEP_W'(dft_pkg::THR_RESET_VALUE);
         tx_hard <= KEEP_W'(dft_pkg::THR_RESET_VALUE);
         tx_soft <= KEEP_W'(dft_pkg::THR_RESET_VALUE);
         rdata   <= 32'h0000_0000;
      end else begin
         rx_hard <= next_rx_hard;
         rx_soft <= next_rx_soft;
         tx_hard <= next_tx_hard;
         tx_soft <= next_tx_soft;
         rdata   <= next_rdata;
      end
   end

   // bus idle qualification
   always_comb begin
      if (ahb_transfer_i) begin
         next_idle_cnt = '0;
      end else if (idle_cnt == dft_pkg::IDLE_CLOCKS) begin
         next_idle_cnt = idle_cnt;
      end else begin
         next_idle_cnt = idle_cnt + 3'h1;
      end
      next_idle = (next_idle_cnt == dft_pkg::IDLE_CLOCKS);
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         idle_cnt <= '0;
         idle     <= 1'b0;
      end else begin
         idle_cnt <= next_idle_cnt;
         idle     <= next_idle;
      end
   end

   assign bus_idle_o = idle;

   // threshold comparisons
   assign rx_hard_hit = over_limit(rx_empty_words_i, rx_hard);
   assign rx_soft_hit = over_limit(rx_empty_words_i, rx_soft) && idle;
   assign tx_hard_hit = over_limit(tx_empty_words_i, tx_hard);
   assign tx_soft_hit = over_limit(tx_empty_words_i, tx_soft) && idle;

   // one request per queue; a new hit in the start cycle re-arms it
   always_comb begin
      next_rx_req = rx_req && !rx_xfer_start_i;
      next_tx_req = tx_req && !tx_xfer_start_i;
      if ((rx_hard_hit || rx_soft_hit) && rx_desc_enqueue_count_i != '0) begin
         next_rx_req = 1'b1;
      end
      if ((tx_hard_hit || tx_soft_hit) && tx_desc_enqueue_count_i != '0) begin
         next_tx_req = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rx_req <= 1'b0;
         tx_req <= 1'b0;
      end else begin
         rx_req <= next_rx_req;
         tx_req <= next_tx_req;
      end
   end

   assign rx_bus_req_o = rx_req;
   assign tx_bus_req_o = tx_req;

   // checks
   property p_hard_now;
      @(posedge clk_i) disable iff (!rstn_i)
      rx_hard_hit && rx_desc_enqueue_count_i != '0 |=> rx_bus_req_o;
   endproperty
   a_hard_now: assert property (p_hard_now) else $error("hard hit gave no request");

   property p_soft_needs_idle;
      @(posedge clk_i) disable iff (!rstn_i)
      $rose(tx_bus_req_o) && !$past(tx_hard_hit) |-> $past(bus_idle_o);
   endproperty
   a_soft_needs_idle: assert property (p_soft_needs_idle)
      else $error("soft request on busy bus");

   property p_enq_gate;
      @(posedge clk_i) disable iff (!rstn_i)
      $rose(rx_bus_req_o) |-> $past(rx_desc_enqueue_count_i) != '0;
   endproperty
   a_enq_gate: assert property (p_enq_gate)
      else $error("request with empty enqueue count");

   property p_hold;
      @(posedge clk_i) disable iff (!rstn_i)
      tx_bus_req_o && !tx_xfer_start_i |=> tx_bus_req_o;
   endproperty
   a_hold: assert property (p_hold) else $error("request dropped before transfer");

   property p_idle_restart;
      @(posedge clk_i) disable iff (!rstn_i)
      ahb_transfer_i |=> !bus_idle_o && idle_cnt == '0;
   endproperty
   a_idle_restart: assert property (p_idle_restart)
      else $error("idle count not restarted");

   property p_idle_four;
      @(posedge clk_i) disable iff (!rstn_i)
      ahb_transfer_i ##1 (!ahb_transfer_i)[*4] |=> bus_idle_o;
   endproperty
   a_idle_four: assert property (p_idle_four)
      else $error("bus not idle after four quiet clocks");

   property p_idle_early;
      @(posedge clk_i) disable iff (!rstn_i)
      ahb_transfer_i ##1 (!ahb_transfer_i)[*3] |-> !bus_idle_o;
   endproperty
   a_idle_early: assert property (p_idle_early) else $error("bus idle too early");

   property p_chip_reset;
      @(posedge clk_i) !rstn_i |=> rx_hard == '0 && rx_soft == '0
                                   && tx_hard == '0 && tx_soft == '0;
   endproperty
   a_chip_reset: assert property (p_chip_reset) else $error("thresholds not cleared");

   property p_soft_reset;
      @(posedge clk_i) disable iff (!rstn_i)
      soft_reset_i && !(access && pwrite_i) |=> $stable(rx_hard) && $stable(tx_soft);
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("soft reset altered threshold");

   property p_low_zero;
      @(posedge clk_i) disable iff (!rstn_i)
      access && !pwrite_i |-> prdata_o == pack_reg(hard_field(prdata_o), soft_field(prdata_o));
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("threshold low bits not zero");

   property p_tx_hard_now;
      @(posedge clk_i) disable iff (!rstn_i)
      tx_hard_hit && tx_desc_enqueue_count_i != '0 |=> tx_bus_req_o;
   endproperty
   a_tx_hard_now: assert property (p_tx_hard_now)
      else $error("tx hard hit gave no request");

   property p_rx_soft_needs_idle;
      @(posedge clk_i) disable iff (!rstn_i)
      $rose(rx_bus_req_o) && !$past(rx_hard_hit) |-> $past(bus_idle_o);
   endproperty
   a_rx_soft_needs_idle: assert property (p_rx_soft_needs_idle)
      else $error("rx soft request on busy bus");

   property p_tx_enq_gate;
      @(posedge clk_i) disable iff (!rstn_i)
      $rose(tx_bus_req_o) |-> $past(tx_desc_enqueue_count_i) != '0;
   endproperty
   a_tx_enq_gate: assert property (p_tx_enq_gate)
      else $error("tx request with empty enqueue count");

   property p_rx_hold;
      @(posedge clk_i) disable iff (!rstn_i)
      rx_bus_req_o && !rx_xfer_start_i |=> rx_bus_req_o;
   endproperty
   a_rx_hold: assert property (p_rx_hold)
      else $error("rx request dropped before transfer");

   property p_idle_saturate;
      @(posedge clk_i) disable iff (!rstn_i)
      bus_idle_o && !ahb_transfer_i |=> bus_idle_o && idle_cnt == dft_pkg::IDLE_CLOCKS;
   endproperty
   a_idle_saturate: assert property (p_idle_saturate)
      else $error("idle count left saturation");

   property p_busy_no_soft;
      @(posedge clk_i) disable iff (!rstn_i)
      !tx_bus_req_o && !tx_hard_hit && !bus_idle_o |=> !tx_bus_req_o;
   endproperty
   a_busy_no_soft: assert property (p_busy_no_soft)
      else $error("request raised on busy bus without hard hit");

   property p_enq_zero_blocks;
      @(posedge clk_i) disable iff (!rstn_i)
      !rx_bus_req_o && rx_desc_enqueue_count_i == '0 |=> !rx_bus_req_o;
   endproperty
   a_enq_zero_blocks: assert property (p_enq_zero_blocks)
      else $error("request posted with no descriptors");

   property p_write_lands;
      @(posedge clk_i) disable iff (!rstn_i)
      access && pwrite_i && rx_hit |=> rx_hard == hard_field($past(pwdata_i))
                                       && rx_soft == soft_field($past(pwdata_i));
   endproperty
   a_write_lands: assert property (p_write_lands)
      else $error("rx threshold write not stored");

   c_hard: cover property (@(posedge clk_i) rx_hard_hit ##1 rx_bus_req_o);
   c_soft: cover property (@(posedge clk_i) tx_soft_hit && !tx_hard_hit ##1 tx_bus_req_o);
   c_start: cover property (@(posedge clk_i) rx_bus_req_o && rx_xfer_start_i);
   c_write: cover property (@(posedge clk_i) access && pwrite_i && tx_hit);
   c_idle: cover property (@(posedge clk_i) $rose(bus_idle_o));

endmodule // dft_threshold

/* File: verif/dft_bus_model.sv */
// bus side model: other masters' traffic and descriptor fetch starts
`timescale 1ns/1ps
module dft_bus_model (
   input  wire logic       clk_i,          // bus clock
   input  wire logic       rstn_i,         // sync reset, low
   input  wire logic       busy_i,         // other masters hold the bus
   input  wire logic       grant_i,        // allowed to answer requests
   input  wire logic [1:0] lat_i,          // answer delay in clocks
   input  wire logic       rx_req_i,       // rx descriptor request
   input  wire logic       tx_req_i,       // tx descriptor request
   output logic            ahb_transfer_o, // transfer on the bus
   output logic            rx_start_o,     // rx fetch begins
   output logic            tx_start_o      // tx fetch begins
);
   logic [1:0] wait_cnt, next_wait_cnt;
   logic       go, next_rx_start, next_tx_start;
   // a fetch is itself bus traffic, so it also spoils idleness
   assign ahb_transfer_o = busy_i | rx_start_o | tx_start_o;
   always_comb begin
      go            = grant_i && (rx_req_i || tx_req_i) && wait_cnt == lat_i;
      next_wait_cnt = (grant_i && (rx_req_i || tx_req_i) && !go) ? wait_cnt + 2'h1 : 2'h0;
      next_rx_start = go && rx_req_i && !rx_start_o;
      next_tx_start = go && tx_req_i && !tx_start_o;
   end
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wait_cnt   <= 2'h0;
         rx_start_o <= 1'b0;
         tx_start_o <= 1'b0;
      end else begin
         wait_cnt   <= next_wait_cnt;
         rx_start_o <= next_rx_start;
         tx_start_o <= next_tx_start;
      end
   end
endmodule // dft_bus_model

/* File: verif/test_desc_fifo_bus_request_threshold.sv */
// testbench for the descriptor fifo bus request threshold block
`timescale 1ns/1ps
module test_desc_fifo_bus_request_threshold;
   logic        clk_i = 1'b0, rstn_i = 1'b0, soft_reset_i = 1'b0;
   logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, busy = 1'b1, grant = 1'b0;
   logic [31:0] paddr_i = '0, pwdata_i = '0, prdata_o, rd;
   logic [6:0]  rx_e = '0, tx_e = '0;
   logic [7:0]  rx_q = '0, tx_q = '0;
   logic [1:0]  lat = '0;
   logic        pready_o, pslverr_o, err, ahb_t, rx_st, tx_st, rx_req, tx_req, idle;
   int          err_total = 0, checks = 0;
   dft_threshold dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .soft_reset_i(soft_reset_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .ahb_transfer_i(ahb_t), .rx_empty_words_i(rx_e), .tx_empty_words_i(tx_e),
      .rx_desc_enqueue_count_i(rx_q), .tx_desc_enqueue_count_i(tx_q),
      .rx_xfer_start_i(rx_st), .tx_xfer_start_i(tx_st), .rx_bus_req_o(rx_req),
      .tx_bus_req_o(tx_req), .bus_idle_o(idle));
   dft_bus_model bus_u (.clk_i(clk_i), .rstn_i(rstn_i), .busy_i(busy), .grant_i(grant),
      .lat_i(lat), .rx_req_i(rx_req), .tx_req_i(tx_req), .ahb_transfer_o(ahb_t),
      .rx_start_o(rx_st), .tx_start_o(tx_st));
   initial forever #20 clk_i = ~clk_i;
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i   <= 1'b1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1) @(posedge clk_i);
      rd = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // strict compare: an empty count equal to the limit asks for nothing
   function automatic logic exp_req(input logic [31:0] t, input logic [6:0] e,
                                    input logic [7:0] q, input logic idl);
      return q != 8'h00 && (e > {1'b0, t[21:18], 2'b00} || (e > {1'b0, t[5:2], 2'b00} && idl));
   endfunction
   task run_case(input logic [31:0] vr, vt, input logic [6:0] re, te,
                 input logic [7:0] rq, tq, input logic b, keep);
      apb(1'b1, dft_pkg::RX_DESC_THR_ADDR, vr);
      apb(1'b1, dft_pkg::TX_DESC_THR_ADDR, vt);
      @(posedge clk_i);
      busy <= b;
      lat  <= 2'($urandom_range(3, 0));
      // enqueue counts follow a clock later so the old idle state cannot leak in
      @(posedge clk_i);
      rx_e <= re;
      tx_e <= te;
      rx_q <= rq;
      tx_q <= tq;
      repeat (8) @(posedge clk_i);
      #1;
      chk("bus_idle", {31'h0, !b}, {31'h0, idle});
      chk("rx_req", {31'h0, exp_req(vr, re, rq, !b)}, {31'h0, rx_req});
      chk("tx_req", {31'h0, exp_req(vt, te, tq, !b)}, {31'h0, tx_req});
      if (keep) begin
         @(posedge clk_i);
         grant <= 1'b1;
         repeat (10) @(posedge clk_i);
         #1;
         chk("rx_req_held", 32'h0000_0001, {31'h0, rx_req});
      end
      @(posedge clk_i);
      rx_q  <= 8'h00;
      tx_q  <= 8'h00;
      grant <= 1'b1;
      repeat (10) @(posedge clk_i);
      #1;
      chk("req_cleared", 32'h0000_0000, {30'h0, rx_req, tx_req});
      @(posedge clk_i);
      grant <= 1'b0;
      $display("case done rx %h tx %h", vr, vt);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'h2e20_20be));
      repeat (8) @(posedge clk_i);
      rstn_i <= 1'b1;
      apb(1'b0, dft_pkg::RX_DESC_THR_ADDR, '0);
      chk("rx_reset", dft_pkg::THR_RESET_VALUE, rd);
      apb(1'b0, dft_pkg::TX_DESC_THR_ADDR, '0);
      chk("tx_reset", dft_pkg::THR_RESET_VALUE, rd);
      apb(1'b1, dft_pkg::RX_DESC_THR_ADDR, 32'hffff_ffff);
      soft_reset_i <= 1'b1;
      apb(1'b0, dft_pkg::RX_DESC_THR_ADDR, '0);
      chk("rx_masked_soft", 32'h003c_003c, rd);
      soft_reset_i <= 1'b0;
      apb(1'b1, dft_pkg::TX_DESC_THR_ADDR, 32'h0004_0002);
      apb(1'b0, dft_pkg::TX_DESC_THR_ADDR, '0);
      chk("tx_advised", 32'h0004_0000, rd);
      apb(1'b0, 32'h8001_00e8, '0);
      chk("unmapped_err", 32'h0000_0001, {31'h0, err});
      $display("register tests done");
      @(posedge clk_i);
      busy <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      chk("idle_early", 32'h0000_0000, {31'h0, idle});
      @(posedge clk_i);
      #1;
      chk("idle_on_time", 32'h0000_0001, {31'h0, idle});
      $display("idle tests done");
      run_case(32'h0008_0000, 32'h0008_0000, 7'd9, 7'd8, 8'h01, 8'h01, 1'b1, 1'b1);
      run_case(32'h003c_0004, 32'h003c_0004, 7'd5, 7'd4, 8'h02, 8'h02, 1'b0, 1'b0);
      run_case(32'h003c_0004, 32'h0007_0003, 7'd5, 7'd5, 8'h02, 8'h01, 1'b1, 1'b0);
      run_case(32'h0000_0000, 32'h0000_0000, 7'd9, 7'd9, 8'h00, 8'hff, 1'b1, 1'b0);
      repeat (30) begin
         run_case($urandom & 32'h003c_003c, $urandom & 32'h003c_003c, 7'($urandom),
                  7'($urandom), 8'($urandom_range(3, 0)), 8'($urandom_range(3, 0)),
                  1'($urandom), 1'b0);
      end
      wrap_up();
   end
endmodule // test_desc_fifo_bus_request_threshold
